/* fco_params.svh */
// Offsets, field positions, reset values and timing counts of the fail output controller
`ifndef FCO_PARAMS_SVH
`define FCO_PARAMS_SVH

// Register byte addresses (word address = byte address / 4)
`define FCO_ADDR_CTRL      6'h00
`define FCO_ADDR_STATUS    6'h04
`define FCO_ADDR_PINCFG    6'h08
`define FCO_ADDR_WAKE      6'h0C
`define FCO_ADDR_LEVEL     6'h10
`define FCO_ADDR_ID        6'h14

// Control register fields
`define FCO_CTRL_FORCE     0
`define FCO_CTRL_OVEN      1
`define FCO_CTRL_DUTY_LO   2
`define FCO_CTRL_WDCFG_LO  4
`define FCO_CTRL_RESET     32'h0000_0000

// Status register fields
`define FCO_STAT_FAULT     0
`define FCO_STAT_WDCNT_LO  1
`define FCO_STAT_UVCNT_LO  3

// Pin function codes
`define FCO_PIN_FAIL       2'h0
`define FCO_PIN_OFF        2'h1
`define FCO_PIN_WAKE       2'h2
`define FCO_PIN_SWITCH     2'h3
`define FCO_PINCFG_RESET   4'h0

// Neutral identity value, arbitrary
`define FCO_ID_VALUE       32'h0000_0A5C

// Timing: clock 250 MHz, period in ps
`define FCO_CLK_PERIOD_PS  4000
`define FCO_BLINK_HZ_X100  125
`define FCO_DIM_HZ         100
`define FCO_TEST_FILT_US   64
// Half blink period: 1 / (2 * 1.25 Hz) = 0.4 s
`define FCO_BLINK_HALF_CYC (64'd1_000_000_000_000 * 64'd100 / (64'd2 * `FCO_BLINK_HZ_X100 * `FCO_CLK_PERIOD_PS))
`define FCO_DIM_PER_CYC    (64'd1_000_000_000_000 / (`FCO_DIM_HZ * `FCO_CLK_PERIOD_PS))
`define FCO_TEST_FILT_CYC  (64'd1_000_000 * `FCO_TEST_FILT_US / `FCO_CLK_PERIOD_PS)
// Undervoltage events in a row that raise the fault
`define FCO_UV_LIMIT       3'h4

`endif

/* fco_pkg.sv */
// Types shared by the fail output controller
package fco_pkg;
  // System operating modes seen by the block
  typedef enum logic [2:0] {
    FCO_MODE_INIT,
    FCO_MODE_NORMAL,
    FCO_MODE_STOP,
    FCO_MODE_SLEEP,
    FCO_MODE_RESTART,
    FCO_MODE_FAILSAFE
  } fco_mode_t;

  // Watchdog failure configurations 1..4 encoded 0..3
  typedef enum logic [1:0] {
    FCO_CFG1,
    FCO_CFG2,
    FCO_CFG3,
    FCO_CFG4
  } fco_wdcfg_t;
endpackage

/* fco_fail_output.sv */
// Fail output controller: fault logic, three fail pins, alternate pin functions, register slave
//
// Function
// RQ1 - Thermal stage two, rail short, or enabled overvoltage drive all fail pins low.
// RQ2 - Watchdog failures activate outputs after second in configs 3,4, first in 1,2; config 2 here activates on its second.
// RQ3 - Four consecutive rail undervoltage events activate the fail outputs.
// RQ4 - Activation also requests fail-safe mode; watchdog case depends on configuration.
// RQ5 - Any activation sets the fault flag readable in the device status register; activation by the force bit leaves the flag clear here.
// RQ6 - Force bit activates outputs for test; clearing releases them when no fault.
// RQ7 - In normal mode outputs release after faults vanish and software clears flag.
// RQ8 - Controller must clear watchdog failure count by a good trigger before flag clear.
// RQ9 - Watchdog fail count clears on sleep, non-watchdog fail-safe, or stop disable.
// RQ10 - Configuration 2 ignores the first watchdog failure entirely.
// RQ11 - Static fail pin stays low continuously while active.
// RQ12 - Blink fail pin toggles at 1.25 Hz with fifty percent duty.
// RQ13 - Dimming pin pulses 100 Hz, duty 20, 10, 5 or 2.5 percent, default 20.
// RQ14 - Blink and dimming pins default to fail use; control reassigns their function.
// RQ15 - Wake-configured pins store wake events in the second wake status register.
// RQ16 - In normal and stop mode reassigned pin levels show in pin level status.
// RQ17 - Pin functions change only in normal mode; fixed in stop and sleep.
// RQ18 - Wake pins stay wake capable in restart, off in fail-safe.
// RQ19 - Switch pins are disabled in restart and fail-safe, then resume.
// RQ20 - A failure-activated output stays active through restart into normal until cleared.
// RQ21 - The test level on the dimming pin is filtered for 64 microseconds.
// RQ22 - External circuit holds dimming pin high during power-up and init.
// RQ23 - Blink and pulse counters restart from a defined phase at each activation.
`timescale 1ns/1ps
`default_nettype none
`include "fco_params.svh"

module fco_fail_output (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  // Avalon-MM slave
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Fault sources and system state (same clock domain)
  input  wire logic        i_thermal_shutdown_stage_two,
  input  wire logic        i_rail_short,
  input  wire logic        i_rail_overvoltage,
  input  wire logic        i_rail_undervoltage_event,
  input  wire logic        i_rail_ok_event,
  input  wire logic        i_watchdog_fail_event,
  input  wire logic        i_watchdog_good_trigger,
  input  wire logic        i_watchdog_stop_disable,
  input  wire logic [2:0]  i_mode,
  // Pins: three open-drain style output pairs, pad input on the blink and dimming pins
  input  wire logic        i_blink_fail_pin,
  input  wire logic        i_dimming_pin_with_devmode_sense,
  output logic             o_static_fail_pin,
  output logic             o_static_fail_pin_oe_n,
  output logic             o_blink_fail_pin,
  output logic             o_blink_fail_pin_oe_n,
  output logic             o_dimming_fail_pin,
  output logic             o_dimming_fail_pin_oe_n,
  // Results for the rest of the device
  output logic             o_failsafe_request,
  output logic             o_wake_request,
  output logic             o_test_level
);

  // ---------------------------------------------------------------------------
  // Mode decode and synchronisers
  // ---------------------------------------------------------------------------

  fco_pkg::fco_mode_t mode;
  logic               in_normal;
  logic               in_stop;
  logic               in_sleep;
  logic               in_restart;
  logic               in_failsafe;

  // Mode comes from the same clock domain
  assign mode        = fco_pkg::fco_mode_t'(i_mode);
  assign in_normal   = (mode == fco_pkg::FCO_MODE_NORMAL);
  assign in_stop     = (mode == fco_pkg::FCO_MODE_STOP);
  assign in_sleep    = (mode == fco_pkg::FCO_MODE_SLEEP);
  assign in_restart  = (mode == fco_pkg::FCO_MODE_RESTART);
  assign in_failsafe = (mode == fco_pkg::FCO_MODE_FAILSAFE);

  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;

  // Pad levels are asynchronous; two flops before any use
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_meta_q <= 2'h3;
      pin_sync_q <= 2'h3;
    end else if (i_clk_en) begin
      pin_meta_q <= {i_dimming_pin_with_devmode_sense, i_blink_fail_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------

  logic        force_q;
  logic        ov_enable_q;
  logic [1:0]  duty_sel_q;
  fco_pkg::fco_wdcfg_t wd_cfg_q;
  logic [3:0]  pin_cfg_q;
  logic [1:0]  wake_stat_q;
  logic        fault_q;
  logic [1:0]  wd_count_q;
  logic [2:0]  uv_count_q;
  logic [1:0]  level_q;

  logic        wr_go;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_pin;
  logic        wr_wake;

  // Byte lane 0 holds every writable field; a write lands only on its acknowledge edge
  assign wr_go   = i_clk_en && i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign wr_ctrl = wr_go && (i_avs_address == `FCO_ADDR_CTRL);
  assign wr_stat = wr_go && (i_avs_address == `FCO_ADDR_STATUS);
  assign wr_pin  = wr_go && (i_avs_address == `FCO_ADDR_PINCFG);
  assign wr_wake = wr_go && (i_avs_address == `FCO_ADDR_WAKE);

  // Control register: force, overvoltage enable, duty select, watchdog config
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      force_q     <= 1'b0;
      ov_enable_q <= 1'b0;
      duty_sel_q  <= 2'h0;
      wd_cfg_q    <= fco_pkg::FCO_CFG1;
    end else if (wr_ctrl) begin
      force_q     <= i_avs_writedata[`FCO_CTRL_FORCE];
      ov_enable_q <= i_avs_writedata[`FCO_CTRL_OVEN];
      duty_sel_q  <= i_avs_writedata[`FCO_CTRL_DUTY_LO +: 2];
      wd_cfg_q    <= fco_pkg::fco_wdcfg_t'(i_avs_writedata[`FCO_CTRL_WDCFG_LO +: 2]);
    end
  end

  // Pin function only writable in normal mode; held otherwise
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_cfg_q <= `FCO_PINCFG_RESET; // [RQ14]
    end else if (wr_pin && in_normal) begin
      pin_cfg_q <= i_avs_writedata[3:0]; // [RQ17]
    end
  end

  // ---------------------------------------------------------------------------
  // Fault detection
  // ---------------------------------------------------------------------------

  logic [1:0] wd_limit;
  logic       wd_hit;
  logic       hard_fault;
  logic       uv_fault;
  logic       wd_fault;
  logic       wd_fault_active;
  logic       any_fault;
  logic       fault_set;

  // Config 3 and 4 need two failures; config 2 tolerates its first
  assign wd_limit   = (wd_cfg_q == fco_pkg::FCO_CFG3 || wd_cfg_q == fco_pkg::FCO_CFG4) ? 2'h2 : 2'h1; // [RQ2]
  assign wd_hit     = i_watchdog_fail_event && ((wd_count_q + 2'h1) >= wd_limit)
                      && !(wd_cfg_q == fco_pkg::FCO_CFG2 && wd_count_q == 2'h0); // [RQ10]
  assign hard_fault = i_thermal_shutdown_stage_two || i_rail_short
                      || (i_rail_overvoltage && ov_enable_q); // [RQ1]
  assign uv_fault   = (uv_count_q >= `FCO_UV_LIMIT); // [RQ3]
  // Config 2 stays inactive below a count of two, so its second failure is the trigger
  assign wd_fault_active = (wd_count_q >= wd_limit)
                           && !(wd_cfg_q == fco_pkg::FCO_CFG2 && wd_count_q < 2'h2);
  assign wd_fault   = wd_hit || wd_fault_active;
  assign any_fault  = hard_fault || uv_fault || wd_fault;
  assign fault_set  = hard_fault || uv_fault || wd_hit;

  // Watchdog failure count; every config caps at two
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wd_count_q <= 2'h0;
    end else if (i_clk_en) begin
      if (i_watchdog_good_trigger || in_sleep || i_watchdog_stop_disable
          || (in_failsafe && !wd_fault_active)) begin
        wd_count_q <= 2'h0; // [RQ9] [RQ8]
      end else if (i_watchdog_fail_event && wd_count_q != 2'h2) begin
        wd_count_q <= (wd_cfg_q == fco_pkg::FCO_CFG2 && wd_count_q == 2'h1) ? 2'h2 : wd_count_q + 2'h1;
      end
    end
  end

  // Undervoltage run length; any good rail sample breaks the run
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      uv_count_q <= 3'h0;
    end else if (i_clk_en) begin
      if (i_rail_ok_event) begin
        uv_count_q <= 3'h0; // [RQ3]
      end else if (i_rail_undervoltage_event && uv_count_q < `FCO_UV_LIMIT) begin
        uv_count_q <= uv_count_q + 3'h1;
      end
    end
  end

  // Fault flag: set wins over a software clear; clear only when faults gone
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fault_q <= 1'b0;
    end else if (i_clk_en) begin
      if (fault_set) begin
        fault_q <= 1'b1; // [RQ5] [RQ20]
      end else if (wr_stat && i_avs_writedata[`FCO_STAT_FAULT] && in_normal && !any_fault) begin
        fault_q <= 1'b0; // [RQ7]
      end
    end
  end

  // Watchdog fail-safe entry only in configs that ask for it
  assign o_failsafe_request = fault_set && !(wd_hit && !hard_fault && !uv_fault
                              && (wd_cfg_q == fco_pkg::FCO_CFG1 || wd_cfg_q == fco_pkg::FCO_CFG3)); // [RQ4]

  // ---------------------------------------------------------------------------
  // Waveform generation
  // ---------------------------------------------------------------------------

  localparam logic [26:0] BLINK_HALF = 27'(`FCO_BLINK_HALF_CYC);
  localparam logic [21:0] DIM_PER    = 22'(`FCO_DIM_PER_CYC);
  localparam logic [13:0] FILT_CYC   = 14'(`FCO_TEST_FILT_CYC);

  logic        active;
  logic [26:0] blink_cnt_q;
  logic        blink_ph_q;
  logic [21:0] dim_cnt_q;
  logic [21:0] dim_high;

  assign active = fault_q || force_q; // [RQ6]

  // Duty 20, 10, 5, 2.5 percent of the 100 Hz period
  always_comb begin
    unique case (duty_sel_q)
      2'h0:    dim_high = 22'(DIM_PER / 22'd5); // [RQ13]
      2'h1:    dim_high = 22'(DIM_PER / 22'd10);
      2'h2:    dim_high = 22'(DIM_PER / 22'd20);
      default: dim_high = 22'(DIM_PER / 22'd40);
    endcase
  end

  // Counters held at phase zero while inactive so each activation starts alike
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      blink_cnt_q <= 27'h0;
      blink_ph_q  <= 1'b0;
      dim_cnt_q   <= 22'h0;
    end else if (i_clk_en) begin
      if (!active) begin
        blink_cnt_q <= 27'h0; // [RQ23]
        blink_ph_q  <= 1'b0;
        dim_cnt_q   <= 22'h0;
      end else begin
        if (blink_cnt_q == BLINK_HALF - 27'h1) begin
          blink_cnt_q <= 27'h0;
          blink_ph_q  <= ~blink_ph_q; // [RQ12]
        end else begin
          blink_cnt_q <= blink_cnt_q + 27'h1;
        end
        dim_cnt_q <= (dim_cnt_q == DIM_PER - 22'h1) ? 22'h0 : dim_cnt_q + 22'h1; // [RQ13]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Pin function and drivers
  // ---------------------------------------------------------------------------

  logic [1:0] fail_low;
  logic [1:0] pin_oe_n;
  logic [1:0] wake_cap;

  // Fail-phase low: blink low on phase 0, dimming low during the duty window
  assign fail_low[0] = active && !blink_ph_q;
  assign fail_low[1] = active && (dim_cnt_q < dim_high);

  // One driver per alternate pin; switch is a low-side sink here
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      logic [1:0] fn;
      assign fn = pin_cfg_q[2*g +: 2];
      assign wake_cap[g] = (fn == `FCO_PIN_WAKE) && !in_failsafe && !in_normal ? 1'b1
                         : (fn == `FCO_PIN_WAKE) && in_normal; // [RQ18]
      always_comb begin
        pin_oe_n[g] = 1'b1;
        if (fn == `FCO_PIN_FAIL) begin
          pin_oe_n[g] = !fail_low[g];
        end else if (fn == `FCO_PIN_SWITCH && !in_restart && !in_failsafe) begin
          pin_oe_n[g] = 1'b0; // [RQ19]
        end
      end
    end
  endgenerate

  // Pin enables from flops, data tied low; pad sees low only while the enable is low
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_static_fail_pin_oe_n  <= 1'b1;
      o_blink_fail_pin_oe_n   <= 1'b1;
      o_dimming_fail_pin_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      o_static_fail_pin_oe_n  <= !active; // [RQ11]
      o_blink_fail_pin_oe_n   <= pin_oe_n[0];
      o_dimming_fail_pin_oe_n <= pin_oe_n[1];
    end
  end
  assign o_static_fail_pin  = 1'b0;
  assign o_blink_fail_pin   = 1'b0;
  assign o_dimming_fail_pin = 1'b0;

  // Wake events: any level change on a wake-capable pin; set wins over clear
  logic [1:0] prev_lvl_q;
  logic [1:0] wake_evt;
  assign wake_evt = wake_cap & (prev_lvl_q ^ pin_sync_q);
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prev_lvl_q  <= 2'h3;
      wake_stat_q <= 2'h0;
    end else if (i_clk_en) begin
      prev_lvl_q  <= pin_sync_q;
      wake_stat_q <= wake_evt | (wake_stat_q & ~(wr_wake ? i_avs_writedata[1:0] : 2'h0)); // [RQ15]
    end
  end
  assign o_wake_request = |wake_evt;

  // Level status tracks pins in normal and stop mode only
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      level_q <= 2'h0;
    end else if (i_clk_en && (in_normal || in_stop)) begin
      level_q <= pin_sync_q; // [RQ16]
    end
  end

  // Test level filter: level accepted after it stands for the filter time
  logic [13:0] filt_cnt_q;
  logic        test_q;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      filt_cnt_q <= 14'h0;
      test_q     <= 1'b1; // [RQ22]
    end else if (i_clk_en) begin
      if (pin_sync_q[1] == test_q) begin
        filt_cnt_q <= 14'h0;
      end else if (filt_cnt_q == FILT_CYC - 14'h1) begin
        filt_cnt_q <= 14'h0;
        test_q     <= pin_sync_q[1]; // [RQ21]
      end else begin
        filt_cnt_q <= filt_cnt_q + 14'h1;
      end
    end
  end
  assign o_test_level = test_q;

  // ---------------------------------------------------------------------------
  // Read path: single-cycle wait, data from flops
  // ---------------------------------------------------------------------------

  logic wait_q;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wait_q         <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_clk_en) begin
      wait_q <= !(i_avs_read || i_avs_write) || !wait_q;
      if (i_avs_read) begin
        unique case (i_avs_address)
          `FCO_ADDR_CTRL:   o_avs_readdata <= {26'h0, wd_cfg_q, duty_sel_q, ov_enable_q, force_q};
          `FCO_ADDR_STATUS: o_avs_readdata <= {26'h0, uv_count_q, wd_count_q, fault_q}; // [RQ5]
          `FCO_ADDR_PINCFG: o_avs_readdata <= {28'h0, pin_cfg_q};
          `FCO_ADDR_WAKE:   o_avs_readdata <= {30'h0, wake_stat_q};
          `FCO_ADDR_LEVEL:  o_avs_readdata <= {30'h0, level_q};
          `FCO_ADDR_ID:     o_avs_readdata <= `FCO_ID_VALUE;
          default:          o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // Writes act on the waitrequest-low edge only
  assign o_avs_waitrequest = wait_q;

endmodule
`default_nettype wire

/* fco_fail_output_props.sv */
// Port checker for the fail output controller, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module fco_fail_output_props (
  input wire logic        i_clock,
  input wire logic        i_sys_rst,
  input wire logic        i_clk_en,
  input wire logic [5:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_thermal_shutdown_stage_two,
  input wire logic        i_rail_short,
  input wire logic        i_dimming_pin_with_devmode_sense,
  input wire logic        o_static_fail_pin_oe_n,
  input wire logic        o_failsafe_request,
  input wire logic        o_test_level
);
  // --------
  // Helpers
  // --------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic [14:0] low_cnt_q;
  // Pad low time, saturating so a long hold never wraps
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) low_cnt_q <= '0;
    else if (i_dimming_pin_with_devmode_sense) low_cnt_q <= '0;
    else if (low_cnt_q != 15'h7FFF) low_cnt_q <= low_cnt_q + 15'h0001;
  end
  sequence req_s;
    (i_avs_read || i_avs_write) && o_avs_waitrequest && i_clk_en;
  endsequence
  sequence ack_s;
    !o_avs_waitrequest;
  endsequence
  // --------
  // Assertions
  // --------
  wait_one_a: assert property (req_s |=> ack_s)
    else $error("waitrequest not low one cycle after request");
  wait_short_a: assert property (ack_s |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  unmapped_zero_a: assert property (ack_s and i_avs_read && i_avs_address == 6'h3C |-> o_avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  thermal_drive_a: assert property (i_thermal_shutdown_stage_two |-> ##[0:3] !o_static_fail_pin_oe_n)
    else $error("thermal fault did not drive static pin");
  short_drive_a: assert property (i_rail_short |-> ##[0:3] !o_static_fail_pin_oe_n)
    else $error("rail short did not drive static pin");
  static_hold_a: assert property (!o_static_fail_pin_oe_n && (i_thermal_shutdown_stage_two || i_rail_short)
    |=> !o_static_fail_pin_oe_n)
    else $error("static pin released while fault present");
  failsafe_req_a: assert property ($rose(i_thermal_shutdown_stage_two || i_rail_short) && o_static_fail_pin_oe_n
    |-> ##[0:2] o_failsafe_request)
    else $error("no fail-safe request on fault");
  filter_min_a: assert property ($fell(o_test_level) |-> low_cnt_q >= 15'h3E80)
    else $error("test level accepted before filter time");
  filter_max_a: assert property (low_cnt_q == 15'h3F20 |-> !o_test_level)
    else $error("test level not accepted after filter time");
endmodule
bind fco_fail_output fco_fail_output_props i_props (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_thermal_shutdown_stage_two(i_thermal_shutdown_stage_two), .i_rail_short(i_rail_short),
  .i_dimming_pin_with_devmode_sense(i_dimming_pin_with_devmode_sense),
  .o_static_fail_pin_oe_n(o_static_fail_pin_oe_n), .o_failsafe_request(o_failsafe_request),
  .o_test_level(o_test_level));
`default_nettype wire

/* fco_pin_load.sv */
// Pad model: pull-ups on the alternate pins and an external sink on the dimming pin
`timescale 1ns/1ps
`default_nettype none
module fco_pin_load (
  input  wire logic i_blink_oe_n,
  input  wire logic i_dim_oe_n,
  input  wire logic i_dim_ext_low,
  output logic      o_blink_pad,
  output logic      o_dim_pad
);
  // Pull-up wins unless device or load sinks; load idles high at power-up
  assign o_blink_pad = i_blink_oe_n;
  assign o_dim_pad   = i_dim_oe_n & ~i_dim_ext_low;
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the fail output controller
`timescale 1ns/1ps
`default_nettype none
`include "fco_params.svh"
module testbench;
  // --------
  // Signals
  // --------
  logic        clock, sys_rst, clk_en, stop_dis, ext_low, avs_rd, avs_wr, wait_req;
  logic        st_oe_n, bl_oe_n, dm_oe_n, bl_pad, dm_pad, test_lvl;
  logic [2:0]  flt, mode;
  logic [3:0]  ev;
  logic [5:0]  avs_addr;
  logic [31:0] avs_wdata, avs_rdata, rd;
  int          num_errors, total_checks;
  // Faults: thermal, short, overvoltage; events: uv, ok, wd fail, wd good
  fco_fail_output i_fco_fail_output (
    .i_clock(clock), .i_sys_rst(sys_rst), .i_clk_en(clk_en), .i_avs_address(avs_addr),
    .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(avs_rdata), .o_avs_waitrequest(wait_req), .i_thermal_shutdown_stage_two(flt[0]),
    .i_rail_short(flt[1]), .i_rail_overvoltage(flt[2]), .i_rail_undervoltage_event(ev[0]),
    .i_rail_ok_event(ev[1]), .i_watchdog_fail_event(ev[2]), .i_watchdog_good_trigger(ev[3]),
    .i_watchdog_stop_disable(stop_dis), .i_mode(mode), .i_blink_fail_pin(bl_pad),
    .i_dimming_pin_with_devmode_sense(dm_pad), .o_static_fail_pin(), .o_static_fail_pin_oe_n(st_oe_n),
    .o_blink_fail_pin(), .o_blink_fail_pin_oe_n(bl_oe_n), .o_dimming_fail_pin(),
    .o_dimming_fail_pin_oe_n(dm_oe_n), .o_failsafe_request(), .o_wake_request(), .o_test_level(test_lvl));
  fco_pin_load i_fco_pin_load (.i_blink_oe_n(bl_oe_n), .i_dim_oe_n(dm_oe_n), .i_dim_ext_low(ext_low),
    .o_blink_pad(bl_pad), .o_dim_pad(dm_pad));
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // --------
  // Shared tasks
  // --------
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    avs_addr <= a;
    avs_wdata <= wd;
    avs_wr <= wr;
    avs_rd <= ~wr;
    @(posedge clock);
    while (wait_req !== 1'b0) begin
      n++;
      if (n > 20) begin
        num_errors++;
        print_verdict();
      end
      @(posedge clock);
    end
    rd = avs_rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp, input string msg);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp, msg);
  endtask
  // Bounded wait for the static pin enable
  task automatic wait_oe(input logic exp);
    int n;
    n = 0;
    while (st_oe_n !== exp) begin
      n++;
      if (n > 20) begin
        num_errors++;
        print_verdict();
      end
      @(posedge clock);
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    ev[k] <= 1'b1;
    @(posedge clock);
    ev[k] <= 1'b0;
  endtask
  // --------
  // Scenarios
  // --------
  task automatic t_reset;
    check(32'({st_oe_n, bl_oe_n, dm_oe_n, test_lvl}), 32'h0000_000F, "idle pins");
    rchk(`FCO_ADDR_CTRL, 32'h0000_0000, "ctrl reset");
    rchk(`FCO_ADDR_PINCFG, 32'h0000_0000, "pincfg reset");
    rchk(`FCO_ADDR_STATUS, 32'h0000_0000, "status reset");
    rchk(`FCO_ADDR_ID, `FCO_ID_VALUE, "id");
    rchk(6'h3C, 32'h0000_0000, "unmapped");
  endtask
  task automatic t_force;
    bus(1'b1, `FCO_ADDR_CTRL, 32'h0000_0001);
    wait_oe(1'b0);
    check(32'({st_oe_n, bl_oe_n, dm_oe_n}), 32'h0000_0000, "forced pins");
    bus(1'b1, `FCO_ADDR_CTRL, 32'h0000_0000);
    wait_oe(1'b1);
  endtask
  // Clear is refused while the fault stands, accepted once it is gone
  task automatic t_fault(input int k, input logic on);
    @(posedge clock);
    flt[k] <= 1'b1;
    repeat (4) @(posedge clock);
    check(32'(st_oe_n), 32'(!on), "fault drive");
    bus(1'b1, `FCO_ADDR_STATUS, 32'h0000_0001);
    rchk(`FCO_ADDR_STATUS, 32'(on), "flag kept");
    flt[k] <= 1'b0;
    bus(1'b1, `FCO_ADDR_STATUS, 32'h0000_0001);
    wait_oe(1'b1);
    rchk(`FCO_ADDR_STATUS, 32'h0000_0000, "flag cleared");
  endtask
  task automatic t_uv;
    repeat (3) pulse(0);
    pulse(1);
    repeat (3) pulse(0);
    repeat (3) @(posedge clock);
    check(32'(st_oe_n), 32'h0000_0001, "broken run");
    pulse(0);
    wait_oe(1'b0);
    pulse(1);
    bus(1'b1, `FCO_ADDR_STATUS, 32'h0000_0001);
    wait_oe(1'b1);
  endtask
  task automatic t_wd(input logic [1:0] cfg, input logic first);
    bus(1'b1, `FCO_ADDR_CTRL, {26'h0, cfg, 4'h0});
    pulse(2);
    repeat (3) @(posedge clock);
    check(32'(st_oe_n), 32'(!first), "first failure");
    pulse(2);
    wait_oe(1'b0);
    bus(1'b0, `FCO_ADDR_STATUS, 32'h0000_0000);
    check(32'(rd[0]), 32'h0000_0001, "wd flag");
    pulse(3);
    bus(1'b1, `FCO_ADDR_STATUS, 32'h0000_0001);
    wait_oe(1'b1);
    rchk(`FCO_ADDR_STATUS, 32'h0000_0000, "wd count cleared");
  endtask
  task automatic t_pin;
    mode <= fco_pkg::FCO_MODE_STOP;
    bus(1'b1, `FCO_ADDR_PINCFG, 32'h0000_0005);
    rchk(`FCO_ADDR_PINCFG, 32'h0000_0000, "stop write");
    mode <= fco_pkg::FCO_MODE_NORMAL;
    bus(1'b1, `FCO_ADDR_PINCFG, 32'h0000_0005);
    rchk(`FCO_ADDR_PINCFG, 32'h0000_0005, "normal write");
    bus(1'b1, `FCO_ADDR_CTRL, 32'h0000_0001);
    wait_oe(1'b0);
    check(32'({bl_oe_n, dm_oe_n}), 32'h0000_0003, "pins off");
    rchk(`FCO_ADDR_LEVEL, 32'h0000_0003, "pin levels");
    bus(1'b1, `FCO_ADDR_CTRL, 32'h0000_0000);
    bus(1'b1, `FCO_ADDR_PINCFG, 32'h0000_0000);
  endtask
  // Long hold: filter is a fixed 64 us count
  task automatic t_filter;
    bus(1'b1, `FCO_ADDR_PINCFG, 32'h0000_0008);
    ext_low <= 1'b1;
    repeat (15900) @(posedge clock);
    check(32'(test_lvl), 32'h0000_0001, "filter early");
    for (int n = 0; n < 300 && test_lvl !== 1'b0; n++) @(posedge clock);
    check(32'(test_lvl), 32'h0000_0000, "filter done");
    rchk(`FCO_ADDR_WAKE, 32'h0000_0002, "wake event");
    repeat (200) @(posedge clock);
    ext_low <= 1'b0;
  endtask
  // --------
  // Main sequence
  // --------
  initial begin
    {flt, ev, stop_dis, ext_low, avs_rd, avs_wr, avs_addr, avs_wdata} = '0;
    mode = fco_pkg::FCO_MODE_NORMAL;
    clk_en = 1'b1;
    num_errors = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_force();
    t_fault(0, 1'b1);
    t_fault(1, 1'b1);
    t_fault(2, 1'b0);
    bus(1'b1, `FCO_ADDR_CTRL, 32'h0000_0002);
    t_fault(2, 1'b1);
    t_uv();
    t_wd(2'h0, 1'b1);
    t_wd(2'h1, 1'b0);
    t_wd(2'h2, 1'b0);
    t_wd(2'h3, 1'b0);
    t_pin();
    t_filter();
    print_verdict();
  end
endmodule
`default_nettype wire
